//--- rtl/msct_top.v
// module standby control registers with an axi4-lite slave
`timescale 1ns/100ps
`default_nettype none
`include "msct_defines.vh"

module msct_top #(
	parameter ADDR_W = 18                     // byte address width
) (
	input  wire              aclk,            // system clock, 10 MHz
	input  wire              aresetn,         // sync reset, active low
	input  wire [ADDR_W-1:0] s_axi_awaddr,    // write address
	input  wire [2:0]        s_axi_awprot,    // write protection, unused
	input  wire              s_axi_awvalid,   // write address valid
	output wire              s_axi_awready,   // write address ready
	input  wire [31:0]       s_axi_wdata,     // write data
	input  wire [3:0]        s_axi_wstrb,     // write byte strobes
	input  wire              s_axi_wvalid,    // write data valid
	output wire              s_axi_wready,    // write data ready
	output wire [1:0]        s_axi_bresp,     // write response
	output wire              s_axi_bvalid,    // write response valid
	input  wire              s_axi_bready,    // write response ready
	input  wire [ADDR_W-1:0] s_axi_araddr,    // read address
	input  wire [2:0]        s_axi_arprot,    // read protection, unused
	input  wire              s_axi_arvalid,   // read address valid
	output wire              s_axi_arready,   // read address ready
	output wire [31:0]       s_axi_rdata,     // read data
	output wire [1:0]        s_axi_rresp,     // read response
	output wire              s_axi_rvalid,    // read data valid
	input  wire              s_axi_rready,    // read data ready
	input  wire              watchdog_running, // watchdog enable, same clock
	output wire              addr_break_standby,   // address break stby
	output wire              pulse_timer_standby,  // timer pulse unit stby
	output wire              two_wire_standby,     // two-wire module stby
	output wire              pwm_b_standby,        // second pwm stby
	output wire              async_event_counter_standby, // event cnt stby
	output wire              watchdog_standby,     // watchdog stby
	output wire              pwm_a_standby,        // first pwm stby
	output wire              lcd_driver_standby,   // lcd driver stby
	output wire              serial_unit_three_ch1_standby, // ch1 stby
	output wire              serial_unit_three_ch2_standby, // ch2 stby
	output wire              serial_unit_three_ch1_reset,   // ch1 reset
	output wire              serial_unit_three_ch2_reset    // ch2 reset
);

	// write path: address and data are held apart and may come in
	// either order; once both are held the register is written on the
	// next edge and bvalid rises with it
	// read path: an address is taken while no answer waits, and the
	// data leave from a flop loaded on the same edge that takes the address
	// at most one read is in flight; a second write may be held while a write response waits
	// only byte lane 0 stores; a write with its lane 0 strobe clear
	// changes nothing but still answers okay
	// unmapped addresses answer slverr and leave both registers alone
	// protection bits and the upper data lanes are ignored on purpose
	// cells 0..7 mirror the bit positions of the second register,
	// cells 8 and 9 are the two serial channels of the first one
	// each cell is a flop, so a module sees a write one edge after the
	// register changes; this costs a cycle but keeps glitches off the
	// standby lines
	// a running watchdog keeps its cell awake; the written bit still
	// reads back and takes hold once the running bit drops
	// software cannot tell from the register whether the watchdog stopped
	// the watchdog running input comes from this clock, so no sync
	// a serial channel is held in reset for its whole standby stay,
	// trading a longer reset for never waking with stale state
	// after reset only the address break unit runs

	// register select codes
	localparam [1:0] SEL_NONE = 2'h0;
	localparam [1:0] SEL_CTL1 = 2'h1;
	localparam [1:0] SEL_CTL2 = 2'h2;

	// number of standby cells: eight in the second register, two serial
	localparam NCELL = 10;

	// reset images as vectors, so single bits can be picked out
	localparam [7:0] CTL1_RST = `MSCT_CTL1_RST;
	localparam [7:0] CTL2_RST = `MSCT_CTL2_RST;

	// reset run values per cell, cells 0..7 follow the second register
	localparam [NCELL-1:0] RUN_RST_ALL =
		{CTL1_RST[`MSCT_SCI_CH2_BIT],
		 CTL1_RST[`MSCT_SCI_CH1_BIT],
		 CTL2_RST};

	// address decode, shared by the write and read paths
	function [1:0] reg_sel;
		input [ADDR_W-1:0] addr;
		begin
			if (addr == `MSCT_CTL1_ADDR)
				reg_sel = SEL_CTL1;
			else if (addr == `MSCT_CTL2_ADDR)
				reg_sel = SEL_CTL2;
			else
				reg_sel = SEL_NONE;
		end
	endfunction

	// write channel state
	reg              aw_held_q;
	reg [ADDR_W-1:0] aw_addr_q;
	reg              w_held_q;
	reg [7:0]        w_data_q;
	reg              w_lane0_q;
	reg              bvalid_q;
	reg [1:0]        bresp_q;

	// read channel state
	reg              rvalid_q;
	reg [7:0]        rdata_q;
	reg [1:0]        rresp_q;

	// the two standby registers
	reg [7:0]        ctl1_q;
	reg [7:0]        ctl2_q;

	wire             aw_take;
	wire             w_take;
	wire             do_write;
	wire [1:0]       wr_sel;
	wire             ar_take;
	wire [1:0]       rd_sel;
	wire             wr_ctl1;
	wire             wr_ctl2;
	wire             wr_miss;

	// named fields of the second register
	wire addr_break_standby_n;
	wire pulse_timer_standby_n;
	wire two_wire_standby_n;
	wire pwm_b_standby_n;
	wire async_event_counter_standby_n;
	wire watchdog_standby_n;
	wire pwm_a_standby_n;
	wire lcd_driver_standby_n;

	// cell vectors
	wire [NCELL-1:0] run_vec;
	wire [NCELL-1:0] hold_vec;
	wire [NCELL-1:0] stby_vec;

	// address and data are each taken once, in either order
	assign s_axi_awready = ~aw_held_q;
	assign s_axi_wready  = ~w_held_q;
	assign aw_take       = s_axi_awvalid & ~aw_held_q;
	assign w_take        = s_axi_wvalid & ~w_held_q;

	// the write is carried out once both halves sit in the holding flops
	assign do_write = aw_held_q & w_held_q & ~bvalid_q;
	assign wr_sel   = reg_sel(aw_addr_q);

	// per-register write strobes; a miss still gets its response
	assign wr_ctl1  = do_write & (wr_sel == SEL_CTL1) & w_lane0_q;
	assign wr_ctl2  = do_write & (wr_sel == SEL_CTL2) & w_lane0_q;
	assign wr_miss  = (wr_sel == SEL_NONE);

	// address holding flop
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q <= 1'b0;
			aw_addr_q <= {ADDR_W{1'b0}};
		end
		else if (aw_take)
		begin
			aw_held_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end
		else if (do_write)
			aw_held_q <= 1'b0;
	end

	// data holding flop; only the low lane carries register bits
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held_q  <= 1'b0;
			w_data_q  <= 8'h00;
			w_lane0_q <= 1'b0;
		end
		else if (w_take)
		begin
			w_held_q  <= 1'b1;
			w_data_q  <= s_axi_wdata[7:0];
			w_lane0_q <= s_axi_wstrb[0];
		end
		else if (do_write)
			w_held_q <= 1'b0;
	end

	// write response; an unmapped address answers slverr and stores nothing
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= `MSCT_RESP_OKAY;
		end
		else if (do_write)
		begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_miss ? `MSCT_RESP_SLVERR
			                                 : `MSCT_RESP_OKAY;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	// second register: every bit stores as written, 1 runs, 0 stands by
	always @(posedge aclk)
	begin
		if (!aresetn)
			ctl2_q <= `MSCT_CTL2_RST;
		else if (wr_ctl2)
			ctl2_q <= w_data_q;
	end

	// first register: only the two serial channel bits exist here,
	// the rest read as zero
	always @(posedge aclk)
	begin
		if (!aresetn)
			ctl1_q <= `MSCT_CTL1_RST;
		else if (wr_ctl1)
			ctl1_q <= w_data_q & `MSCT_CTL1_MASK;
	end

	// read channel: one read at a time, data come from a flop
	assign s_axi_arready = ~rvalid_q;
	assign ar_take       = s_axi_arvalid & ~rvalid_q;
	assign rd_sel        = reg_sel(s_axi_araddr);

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= 8'h00;
			rresp_q  <= `MSCT_RESP_OKAY;
		end
		else if (ar_take)
		begin
			rvalid_q <= 1'b1;
			case (rd_sel)
				SEL_CTL1:
				begin
					rdata_q <= ctl1_q;
					rresp_q <= `MSCT_RESP_OKAY;
				end
				SEL_CTL2:
				begin
					// the watchdog bit shows what was written, not
					// whether the watchdog really stopped
					rdata_q <= ctl2_q;
					rresp_q <= `MSCT_RESP_OKAY;
				end
				default:
				begin
					rdata_q <= 8'h00;
					rresp_q <= `MSCT_RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = {24'h000000, rdata_q};
	assign s_axi_rresp  = rresp_q;

	// field view of the second register
	assign addr_break_standby_n          = ctl2_q[`MSCT_ADBRK_BIT];
	assign pulse_timer_standby_n         = ctl2_q[`MSCT_PTMR_BIT];
	assign two_wire_standby_n            = ctl2_q[`MSCT_TWI_BIT];
	assign pwm_b_standby_n               = ctl2_q[`MSCT_PWMB_BIT];
	assign async_event_counter_standby_n = ctl2_q[`MSCT_AEC_BIT];
	assign watchdog_standby_n            = ctl2_q[`MSCT_WDT_BIT];
	assign pwm_a_standby_n               = ctl2_q[`MSCT_PWMA_BIT];
	assign lcd_driver_standby_n          = ctl2_q[`MSCT_LCD_BIT];

	// run bits in cell order, serial channels on top
	assign run_vec[`MSCT_ADBRK_BIT] = addr_break_standby_n;
	assign run_vec[`MSCT_PTMR_BIT]  = pulse_timer_standby_n;
	assign run_vec[`MSCT_TWI_BIT]   = two_wire_standby_n;
	assign run_vec[`MSCT_PWMB_BIT]  = pwm_b_standby_n;
	assign run_vec[`MSCT_AEC_BIT]   = async_event_counter_standby_n;
	assign run_vec[`MSCT_WDT_BIT]   = watchdog_standby_n;
	assign run_vec[`MSCT_PWMA_BIT]  = pwm_a_standby_n;
	assign run_vec[`MSCT_LCD_BIT]   = lcd_driver_standby_n;
	assign run_vec[8] = ctl1_q[`MSCT_SCI_CH1_BIT];
	assign run_vec[9] = ctl1_q[`MSCT_SCI_CH2_BIT];

	// a running watchdog cannot be stopped from here; once software
	// drops its running bit, a pending 0 takes effect on the next edge
	assign hold_vec = {{(NCELL-`MSCT_WDT_BIT-1){1'b0}},
	                   watchdog_running,
	                   {`MSCT_WDT_BIT{1'b0}}};

	// one registered standby output per peripheral
	genvar gi;
	generate
		for (gi = 0; gi < NCELL; gi = gi + 1)
		begin : g_cell
			msct_stby_cell #(
				.RUN_RST (RUN_RST_ALL[gi])
			) u_cell (
				.aclk     (aclk),
				.aresetn  (aresetn),
				.run_bit  (run_vec[gi]),
				.hold_run (hold_vec[gi]),
				.standby  (stby_vec[gi])
			);
		end
	endgenerate

	// standby outputs to the peripherals
	assign addr_break_standby          = stby_vec[`MSCT_ADBRK_BIT];
	assign pulse_timer_standby         = stby_vec[`MSCT_PTMR_BIT];
	assign two_wire_standby            = stby_vec[`MSCT_TWI_BIT];
	assign pwm_b_standby               = stby_vec[`MSCT_PWMB_BIT];
	assign async_event_counter_standby = stby_vec[`MSCT_AEC_BIT];
	assign watchdog_standby            = stby_vec[`MSCT_WDT_BIT];
	assign pwm_a_standby               = stby_vec[`MSCT_PWMA_BIT];
	assign lcd_driver_standby          = stby_vec[`MSCT_LCD_BIT];
	assign serial_unit_three_ch1_standby = stby_vec[8];
	assign serial_unit_three_ch2_standby = stby_vec[9];

	// a serial channel in standby is held in reset for its whole stay,
	// so it always wakes with every register at its reset value
	assign serial_unit_three_ch1_reset = stby_vec[8];
	assign serial_unit_three_ch2_reset = stby_vec[9];

endmodule

`default_nettype wire

//--- rtl/msct_defines.vh
// constants of the module standby control block
// Function
// - bit 7 of the second register runs the address break unit when 1, stands it by when 0, and resets to 1.
// - bit 6 stands the timer pulse unit by when cleared and resets to 0.
// - bit 5 holds the two-wire bus module in standby whenever it is 0.
// - bit 4 holds the second pwm module in standby while it is 0.
// - bit 3 holds the asynchronous event counter in standby while it is 0.
// - bit 2 asks for watchdog standby when cleared, subject to the interlock.
// - bit 1 holds the first pwm module in standby while it is 0.
// - bit 0 holds the lcd controller/driver in standby while it is 0.
// - writing 1 to a standby bit lets its module run normally.
// - the watchdog standby bit only acts while the watchdog running bit is 0.
// - clearing the watchdog bit while the watchdog runs reads back 0 but the watchdog keeps counting.
// - when the running bit later drops with the standby bit already 0, the watchdog enters standby.
// - a serial unit three channel in standby has all its registers forced to reset.
// - the two serial unit three channels are stood by from bits 6 and 5 of the first register when 0.
`ifndef MSCT_DEFINES_VH
`define MSCT_DEFINES_VH

// register indexes; byte address is four times the index
`define MSCT_CTL1_INDEX      16'hFFFA
`define MSCT_CTL2_INDEX      16'hFFFB
`define MSCT_CTL1_ADDR       {`MSCT_CTL1_INDEX, 2'b00}
`define MSCT_CTL2_ADDR       {`MSCT_CTL2_INDEX, 2'b00}

// bit positions in module_standby_control_two
`define MSCT_ADBRK_BIT       7
`define MSCT_PTMR_BIT        6
`define MSCT_TWI_BIT         5
`define MSCT_PWMB_BIT        4
`define MSCT_AEC_BIT         3
`define MSCT_WDT_BIT         2
`define MSCT_PWMA_BIT        1
`define MSCT_LCD_BIT         0

// bit positions in the first standby register
`define MSCT_SCI_CH1_BIT     6
`define MSCT_SCI_CH2_BIT     5

// reset values and implemented-bit mask
`define MSCT_CTL2_RST        8'h80
`define MSCT_CTL1_RST        8'h00
`define MSCT_CTL1_MASK       8'h60

// bus responses
`define MSCT_RESP_OKAY       2'h0
`define MSCT_RESP_SLVERR     2'h2

`endif

//--- rtl/msct_stby_cell.v
// registered standby output for one peripheral
`timescale 1ns/100ps
`default_nettype none

module msct_stby_cell #(
	parameter RUN_RST = 1'b0          // reset value of the run bit
) (
	input  wire aclk,                 // system clock
	input  wire aresetn,              // synchronous reset, active low
	input  wire run_bit,              // register bit, 1 runs the module
	input  wire hold_run,             // forces run regardless of the bit
	output wire standby               // 1 holds the module in standby
);

	reg standby_q;
	wire standby_d;

	// standby only when the bit is 0 and nothing holds the module running
	assign standby_d = ~run_bit & ~hold_run;

	// one flop so the output follows the run bit and hold_run one edge late
	always @(posedge aclk)
	begin
		if (!aresetn)
			standby_q <= ~RUN_RST;
		else
			standby_q <= standby_d;
	end

	assign standby = standby_q;

endmodule

`default_nettype wire

//--- bench/msct_monitor.sv
// concurrent checks of the standby outputs against bus writes
`timescale 1ns/100ps
`default_nettype none
`include "msct_defines.vh"

module msct_monitor #(
	parameter ADDR_W = 18                       // byte address width
) (
	input wire logic              aclk,                          // clock
	input wire logic              aresetn,                       // reset
	input wire logic [ADDR_W-1:0] s_axi_awaddr,                  // address
	input wire logic              s_axi_awvalid,                 // aw valid
	input wire logic              s_axi_awready,                 // aw ready
	input wire logic [31:0]       s_axi_wdata,                   // data
	input wire logic [3:0]        s_axi_wstrb,                   // strobes
	input wire logic              s_axi_wvalid,                  // w valid
	input wire logic              s_axi_wready,                  // w ready
	input wire logic              s_axi_bvalid,                  // b valid
	input wire logic              watchdog_running,              // wdt on
	input wire logic              addr_break_standby,            // stby
	input wire logic              pulse_timer_standby,           // stby
	input wire logic              two_wire_standby,              // stby
	input wire logic              pwm_b_standby,                 // stby
	input wire logic              async_event_counter_standby,   // stby
	input wire logic              watchdog_standby,              // stby
	input wire logic              pwm_a_standby,                 // stby
	input wire logic              lcd_driver_standby,            // stby
	input wire logic              serial_unit_three_ch1_standby, // stby
	input wire logic              serial_unit_three_ch2_standby, // stby
	input wire logic              serial_unit_three_ch1_reset,   // reset
	input wire logic              serial_unit_three_ch2_reset    // reset
);
	logic [ADDR_W-1:0] aw_q;
	logic [7:0]        wd_q;
	logic              ws_q;
	logic              bv_q;
	logic              wbit_q;
	wire               wr_ok = s_axi_bvalid && !bv_q && ws_q;
	wire               wr2 = wr_ok && (aw_q == `MSCT_CTL2_ADDR);
	wire               wr1 = wr_ok && (aw_q == `MSCT_CTL1_ADDR);

	// capture each write so the outcome can be judged when it lands
	always @(posedge aclk)
	begin
		if (s_axi_awvalid && s_axi_awready)
			aw_q <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready)
			wd_q <= s_axi_wdata[7:0];
		if (s_axi_wvalid && s_axi_wready)
			ws_q <= s_axi_wstrb[0];
		bv_q   <= aresetn && s_axi_bvalid;
		wbit_q <= !aresetn ? 1'b0 : (wr2 ? wd_q[2] : wbit_q);
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_adbrk; wr2 |=> addr_break_standby == !wd_q[7]; endproperty
	a_adbrk: assert property (p_adbrk) else $error("addr break");
	property p_tpu; wr2 |=> pulse_timer_standby == !wd_q[6]; endproperty
	a_tpu: assert property (p_tpu) else $error("pulse timer");
	property p_twi; wr2 |=> two_wire_standby == !wd_q[5]; endproperty
	a_twi: assert property (p_twi) else $error("two wire");
	property p_pwmb; wr2 |=> pwm_b_standby == !wd_q[4]; endproperty
	a_pwmb: assert property (p_pwmb) else $error("pwm b");
	property p_aec; wr2 |=> async_event_counter_standby == !wd_q[3];
	endproperty
	a_aec: assert property (p_aec) else $error("event counter");
	property p_pwma; wr2 |=> pwm_a_standby == !wd_q[1]; endproperty
	a_pwma: assert property (p_pwma) else $error("pwm a");
	property p_wdbit;
		wr2 && !watchdog_running |=> watchdog_standby == !wd_q[2];
	endproperty
	a_wdbit: assert property (p_wdbit) else $error("wdt bit");
	property p_lcd; wr2 |=> lcd_driver_standby == !wd_q[0]; endproperty
	a_lcd: assert property (p_lcd) else $error("lcd driver");
	property p_watchdog_running; watchdog_running |=> !watchdog_standby; endproperty
	a_watchdog_running: assert property (p_watchdog_running) else $error("wdt stopped");
	property p_wdoff;
		$fell(watchdog_running) && !wbit_q && !wr2 |=> watchdog_standby;
	endproperty
	a_wdoff: assert property (p_wdoff) else $error("wdt runs");
	property p_serrst; serial_unit_three_ch1_reset ==
		serial_unit_three_ch1_standby && serial_unit_three_ch2_reset ==
		serial_unit_three_ch2_standby; endproperty
	a_serrst: assert property (p_serrst) else $error("serial rst");
	property p_ser; wr1 |=> serial_unit_three_ch1_standby == !wd_q[6] &&
		serial_unit_three_ch2_standby == !wd_q[5]; endproperty
	a_ser: assert property (p_ser) else $error("serial stby");
endmodule

bind msct_top msct_monitor #(.ADDR_W(ADDR_W)) u_mon (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .watchdog_running(watchdog_running),
	.addr_break_standby(addr_break_standby),
	.pulse_timer_standby(pulse_timer_standby),
	.two_wire_standby(two_wire_standby), .pwm_b_standby(pwm_b_standby),
	.async_event_counter_standby(async_event_counter_standby),
	.watchdog_standby(watchdog_standby), .pwm_a_standby(pwm_a_standby),
	.lcd_driver_standby(lcd_driver_standby),
	.serial_unit_three_ch1_standby(serial_unit_three_ch1_standby),
	.serial_unit_three_ch2_standby(serial_unit_three_ch2_standby),
	.serial_unit_three_ch1_reset(serial_unit_three_ch1_reset),
	.serial_unit_three_ch2_reset(serial_unit_three_ch2_reset));
`default_nettype wire

//--- bench/msct_wdt_model.sv
// watchdog stand-in that counts unless stood by
`timescale 1ns/100ps
`default_nettype none

module msct_wdt_model (
	input  wire logic       aclk,      // clock
	input  wire logic       aresetn,   // sync reset, active low
	input  wire logic       on_req,    // software sets the running bit
	input  wire logic       standby,   // standby from the block
	output var  logic       running_q, // watchdog running bit
	output var  logic [7:0] count_q    // advances while not stood by
);
	// running bit follows software one edge late, like a register
	always @(posedge aclk)
	begin
		running_q <= aresetn && on_req;
		count_q   <= !aresetn ? 8'h00 : (standby ? count_q : count_q + 8'h01);
	end
endmodule
`default_nettype wire

//--- bench/module_standby_control_two_tb.sv
// self-checking bench of the module standby control block
`timescale 1ns/100ps
`default_nettype none
`include "msct_defines.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
	$display("Error %0t: got %h want %h", $time, a, e); end end

module module_standby_control_two_tb;
	logic        aclk = 1'b0, aresetn = 1'b0, on_req = 1'b0;
	logic [17:0] s_axi_awaddr = 18'h00000, s_axi_araddr = 18'h00000;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire         s_axi_rvalid, watchdog_running;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire [7:0]   wd_count;
	wire         addr_break_standby, pulse_timer_standby, two_wire_standby;
	wire         pwm_b_standby, async_event_counter_standby, pwm_a_standby;
	wire         watchdog_standby, lcd_driver_standby;
	wire         serial_unit_three_ch1_standby, serial_unit_three_ch2_standby;
	wire         serial_unit_three_ch1_reset, serial_unit_three_ch2_reset;
	wire [7:0]   sb = {addr_break_standby, pulse_timer_standby,
		two_wire_standby, pwm_b_standby, async_event_counter_standby,
		watchdog_standby, pwm_a_standby, lcd_driver_standby};
	wire [3:0]   ser = {serial_unit_three_ch1_standby,
		serial_unit_three_ch2_standby, serial_unit_three_ch1_reset,
		serial_unit_three_ch2_reset};
	int          checks = 0, miscompares = 0;
	logic [1:0]  rsp;
	logic [31:0] rd;
	logic [7:0]  c;

	msct_top DUT (.*);
	msct_wdt_model u_wdt (.aclk(aclk), .aresetn(aresetn), .on_req(on_req),
		.standby(watchdog_standby), .running_q(watchdog_running),
		.count_q(wd_count));

	initial forever #50 aclk = ~aclk;

	// ready is looked at mid-cycle, where it has settled
	task wr(input [17:0] a, input [7:0] d, input [3:0] s, output [1:0] r);
		logic ta, tw, b;
		begin
			@(posedge aclk);
			s_axi_awaddr  <= a;
			s_axi_wdata   <= {24'h000000, d};
			s_axi_wstrb   <= s;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid  <= 1'b1;
			s_axi_bready  <= 1'b1;
			b = 1'b0;
			while (!b)
			begin
				@(negedge aclk);
				ta = s_axi_awvalid && s_axi_awready;
				tw = s_axi_wvalid && s_axi_wready;
				b  = s_axi_bvalid;
				r  = s_axi_bresp;
				@(posedge aclk);
				if (ta) s_axi_awvalid <= 1'b0;
				if (tw) s_axi_wvalid <= 1'b0;
			end
			s_axi_bready <= 1'b0;
		end
	endtask

	task rd_reg(input [17:0] a, output [31:0] d, output [1:0] r);
		logic ta, v;
		begin
			@(posedge aclk);
			s_axi_araddr  <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready  <= 1'b1;
			v = 1'b0;
			while (!v)
			begin
				@(negedge aclk);
				ta = s_axi_arvalid && s_axi_arready;
				v  = s_axi_rvalid;
				d  = s_axi_rdata;
				r  = s_axi_rresp;
				@(posedge aclk);
				if (ta) s_axi_arvalid <= 1'b0;
			end
			s_axi_rready <= 1'b0;
		end
	endtask

	// a running watchdog never stands by, whatever its bit says
	task sbchk(input [7:0] r2);
		logic [7:0] e;
		begin
			@(negedge aclk);
			e = ~r2;
			if (watchdog_running) e[2] = 1'b0;
			`CHK(sb, e)
		end
	endtask

	task wrap_up;
		begin
			$display("checks %0d miscompares %0d", checks, miscompares);
			if (miscompares == 0 && checks > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask

	initial
	begin
		repeat (3000) @(posedge aclk);
		miscompares++;
		wrap_up;
	end

	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd_reg(`MSCT_CTL2_ADDR, rd, rsp);
		`CHK(rd, 32'h00000080)
		sbchk(8'h80);
		rd_reg(`MSCT_CTL1_ADDR, rd, rsp);
		`CHK(rd, 32'h00000000)
		`CHK(ser, 4'hF)
		$display("test reset done");
		for (int i = 0; i < 8; i++)
		begin
			wr(`MSCT_CTL2_ADDR, 8'h01 << i, 4'h1, rsp);
			sbchk(8'h01 << i);
			rd_reg(`MSCT_CTL2_ADDR, rd, rsp);
			`CHK(rd[7:0], 8'h01 << i)
		end
		wr(`MSCT_CTL2_ADDR, 8'h00, 4'h0, rsp);
		`CHK(rsp, `MSCT_RESP_OKAY)
		wr(18'h00000, 8'h55, 4'h1, rsp);
		`CHK(rsp, `MSCT_RESP_SLVERR)
		rd_reg(18'h00004, rd, rsp);
		`CHK({rsp, rd}, {`MSCT_RESP_SLVERR, 32'h00000000})
		sbchk(8'h80);
		wr(`MSCT_CTL2_ADDR, 8'hFF, 4'h1, rsp);
		sbchk(8'hFF);
		$display("test walk done");
		on_req <= 1'b1;
		wr(`MSCT_CTL2_ADDR, 8'hFB, 4'h1, rsp);
		rd_reg(`MSCT_CTL2_ADDR, rd, rsp);
		`CHK(rd[7:0], 8'hFB)
		sbchk(8'hFB);
		c = wd_count;
		repeat (4) @(posedge aclk);
		@(negedge aclk);
		`CHK(wd_count, c + 8'h04)
		@(posedge aclk);
		on_req <= 1'b0;
		repeat (3) @(posedge aclk);
		sbchk(8'hFB);
		c = wd_count;
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		`CHK(wd_count, c)
		$display("test watchdog done");
		wr(`MSCT_CTL1_ADDR, 8'hFF, 4'h1, rsp);
		rd_reg(`MSCT_CTL1_ADDR, rd, rsp);
		`CHK(rd, 32'h00000060)
		`CHK(ser, 4'h0)
		wr(`MSCT_CTL1_ADDR, 8'h40, 4'h1, rsp);
		@(negedge aclk);
		`CHK(ser, 4'h5)
		$display("test serial done");
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd_reg(`MSCT_CTL2_ADDR, rd, rsp);
		`CHK(rd, 32'h00000080)
		sbchk(8'h80);
		$display("test second reset done");
		wrap_up;
	end
endmodule
`default_nettype wire
